// *** design/gtl_cfg.svh ***
`ifndef GTL_CFG_SVH
`define GTL_CFG_SVH

`define GTL_CMD_DCL 7'h14
`define GTL_CMD_SDC 7'h04
`define GTL_CMD_SPE 7'h18
`define GTL_CMD_SPD 7'h19
`define GTL_CMD_UNL 7'h3F
`define GTL_GRP_LISTEN 2'h1
`define GTL_GRP_TALK 2'h2
`define GTL_ADDR_MAX 5'h1E
`define GTL_RSV_BIT 6
`define GTL_FIFO_DEPTH 16
`define GTL_WORD_W 9

`endif

// *** design/gtl_pkg.sv ***
`default_nettype none
package gtl_pkg;

  // Bus levels as seen on the wires: low means asserted.
  typedef struct packed {
    logic atn_n;
    logic ifc_n;
    logic ren_n;
    logic eoi_n;
    logic dav_n;
    logic nrfd_n;
    logic ndac_n;
    logic [7:0] dio_n;
  } gtl_bus_in_t;

  // Each pin as value and enable; enable is low while the pin is driven.
  typedef struct packed {
    logic [7:0] dio_n;
    logic dio_oen;
    logic eoi_n;
    logic eoi_oen;
    logic dav_n;
    logic dav_oen;
    logic nrfd_n;
    logic nrfd_oen;
    logic ndac_n;
    logic ndac_oen;
    logic srq_n;
    logic srq_oen;
  } gtl_bus_out_t;

  // One message byte and its end-of-message mark.
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } gtl_word_t;

  typedef enum logic [1:0] {SRC_IDLE, SRC_RDY, SRC_DAV, SRC_DONE} gtl_src_t;
  typedef enum logic [1:0] {ACC_IDLE, ACC_RDY, ACC_TAKE} gtl_acc_t;

endpackage
`default_nettype wire

// *** design/gtl_talker_listener.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gtl_cfg.svh"

// ****************************************************************
// Transmit buffer.
// ****************************************************************
module gtl_fifo #(
  parameter int W = `GTL_WORD_W,
  parameter int D = `GTL_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
    $error("FIFO depth must be a power of two, at least two.");
  end

  logic [W-1:0] mem [D];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  logic [AW:0] nxt_wr;
  logic [AW:0] nxt_rd;
  logic in_ready_ff;
  logic push;
  logic pop;

  assign push = in_valid & in_ready_ff;
  assign pop = out_valid & out_ready;
  assign out_valid = wr_ff != rd_ff;
  assign out_data = mem[rd_ff[AW-1:0]];
  assign in_ready = in_ready_ff;
  assign nxt_wr = wr_ff + {{AW{1'b0}}, push};
  assign nxt_rd = rd_ff + {{AW{1'b0}}, pop};

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_ff <= '0;
      rd_ff <= '0;
      in_ready_ff <= 1'b0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      in_ready_ff <= (nxt_wr - nxt_rd) != (AW + 1)'(D);
    end
  end
endmodule

// ****************************************************************
// Talker and listener interface functions.
// ****************************************************************
module gtl_talker_listener
  import gtl_pkg::*;
#(
  parameter int FIFO_DEPTH = `GTL_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire gtl_bus_in_t bus_i,
  output gtl_bus_out_t bus_o,
  input wire logic [4:0] bus_addr,
  input wire logic talk_only,
  input wire logic eoi_out_en,
  input wire logic eoi_in_en,
  input wire logic srq_event,
  input wire logic [7:0] status_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire gtl_word_t tx_data,
  output logic rx_valid,
  output gtl_word_t rx_data,
  output logic dev_clear,
  output logic talker,
  output logic listener,
  output logic spoll,
  output logic rsv
);
  if (FIFO_DEPTH < 2) begin : g_chk
    $error("Transmit buffer needs at least two words.");
  end

  // ****************************************************************
  // Bus conditions.
  // ****************************************************************
  logic atn;
  logic ifc;
  logic dav;
  logic eoi;
  logic [7:0] bus_byte;
  logic talk_ff;
  logic listen_ff;
  logic spm_ff;
  logic rsv_ff;
  logic src_act;
  logic acc_act;

  // The remote enable line is left unread.
  assign atn = ~bus_i.atn_n;
  assign ifc = ~bus_i.ifc_n;
  assign dav = ~bus_i.dav_n;
  assign eoi = ~bus_i.eoi_n;
  assign bus_byte = ~bus_i.dio_n;
  assign src_act = (talk_ff | talk_only) & ~atn & ~ifc;
  assign acc_act = (listen_ff | atn) & ~ifc;

  // ****************************************************************
  // Transmit buffer.
  // ****************************************************************
  logic f_valid;
  logic f_pop;
  gtl_word_t f_word;

  gtl_fifo #(.W($bits(gtl_word_t)), .D(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_word)
  );

  // ****************************************************************
  // Acceptor handshake.
  // ****************************************************************
  gtl_acc_t acc_ff;
  gtl_acc_t nxt_acc;
  logic cap;
  logic cmd_cap;
  logic nrfd_oen_ff;
  logic ndac_oen_ff;

  assign cap = acc_act & (acc_ff == ACC_RDY) & dav;
  assign cmd_cap = cap & atn;

  always_comb begin
    nxt_acc = acc_ff;
    case (acc_ff)
      ACC_IDLE: begin
        if (acc_act) begin
          nxt_acc = ACC_RDY;
        end
      end
      ACC_RDY: begin
        if (!acc_act) begin
          nxt_acc = ACC_IDLE;
        end else if (dav) begin
          nxt_acc = ACC_TAKE;
        end
      end
      ACC_TAKE: begin
        if (!acc_act) begin
          nxt_acc = ACC_IDLE;
        end else if (!dav) begin
          nxt_acc = ACC_RDY;
        end
      end
      default: nxt_acc = ACC_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      acc_ff <= ACC_IDLE;
      nrfd_oen_ff <= 1'b1;
      ndac_oen_ff <= 1'b1;
    end else begin
      acc_ff <= nxt_acc;
      nrfd_oen_ff <= nxt_acc != ACC_TAKE;
      ndac_oen_ff <= nxt_acc != ACC_RDY;
    end
  end

  // ****************************************************************
  // Command decode and addressing.
  // ****************************************************************
  logic addr_ok;
  logic is_mla;
  logic is_mta;
  logic is_ota;
  logic [6:0] cmd;
  logic dev_clear_ff;

  assign cmd = bus_byte[6:0];
  assign addr_ok = bus_addr <= `GTL_ADDR_MAX;
  assign is_mla = cmd[6:5] == `GTL_GRP_LISTEN && cmd[4:0] == bus_addr
    && addr_ok;
  assign is_mta = cmd[6:5] == `GTL_GRP_TALK && cmd[4:0] == bus_addr
    && addr_ok;
  assign is_ota = cmd[6:5] == `GTL_GRP_TALK && !is_mta;

  always_ff @(posedge mclk) begin
    if (!rstn || ifc) begin
      listen_ff <= 1'b0;
    end else if (cmd_cap) begin
      if (is_mla) begin
        listen_ff <= 1'b1;
      end else if (is_mta || cmd == `GTL_CMD_UNL) begin
        listen_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn || ifc) begin
      talk_ff <= 1'b0;
    end else if (cmd_cap) begin
      if (is_mta) begin
        talk_ff <= 1'b1;
      end else if (is_mla || is_ota) begin
        talk_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn || ifc) begin
      spm_ff <= 1'b0;
    end else if (cmd_cap && cmd == `GTL_CMD_SPE) begin
      spm_ff <= 1'b1;
    end else if (cmd_cap && cmd == `GTL_CMD_SPD) begin
      spm_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dev_clear_ff <= 1'b0;
    end else begin
      dev_clear_ff <= cmd_cap && (cmd == `GTL_CMD_DCL
        || (cmd == `GTL_CMD_SDC && listen_ff));
    end
  end

  // ****************************************************************
  // Received data.
  // ****************************************************************
  logic rx_valid_ff;
  gtl_word_t rx_ff;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_valid_ff <= 1'b0;
      rx_ff <= '0;
    end else begin
      rx_valid_ff <= cap & ~atn & listen_ff;
      if (cap && !atn) begin
        rx_ff <= '{last: eoi & eoi_in_en, data: bus_byte};
      end
    end
  end

  // ****************************************************************
  // Source handshake.
  // ****************************************************************
  gtl_src_t src_ff;
  gtl_src_t nxt_src;
  logic have_byte;
  logic stb_sent;
  logic [7:0] dio_n_ff;
  logic last_ff;
  logic dav_oen_ff;
  logic dio_oen_ff;
  logic eoi_oen_ff;
  logic [7:0] stb;

  assign have_byte = spm_ff | f_valid;
  assign f_pop = (src_ff == SRC_DAV) & src_act & bus_i.ndac_n & ~spm_ff;
  assign stb_sent = (src_ff == SRC_DAV) & src_act & bus_i.ndac_n & spm_ff;

  always_comb begin
    stb = status_byte;
    stb[`GTL_RSV_BIT] = rsv_ff;
  end

  always_comb begin
    nxt_src = src_ff;
    case (src_ff)
      SRC_IDLE: begin
        if (src_act && have_byte) begin
          nxt_src = SRC_RDY;
        end
      end
      SRC_RDY: begin
        if (!src_act) begin
          nxt_src = SRC_IDLE;
        end else if (bus_i.nrfd_n) begin
          nxt_src = SRC_DAV;
        end
      end
      SRC_DAV: begin
        if (!src_act) begin
          nxt_src = SRC_IDLE;
        end else if (bus_i.ndac_n) begin
          nxt_src = SRC_DONE;
        end
      end
      SRC_DONE: nxt_src = SRC_IDLE;
      default: nxt_src = SRC_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      src_ff <= SRC_IDLE;
      dav_oen_ff <= 1'b1;
      dio_oen_ff <= 1'b1;
    end else begin
      src_ff <= nxt_src;
      dav_oen_ff <= nxt_src != SRC_DAV;
      dio_oen_ff <= nxt_src == SRC_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dio_n_ff <= 8'hFF;
      last_ff <= 1'b0;
    end else if (src_ff == SRC_IDLE && nxt_src == SRC_RDY) begin
      dio_n_ff <= ~(spm_ff ? stb : f_word.data);
      last_ff <= ~spm_ff & f_word.last;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      eoi_oen_ff <= 1'b1;
    end else begin
      eoi_oen_ff <= !(nxt_src != SRC_IDLE && eoi_out_en && (nxt_src ==
        SRC_RDY && src_ff == SRC_IDLE ? ~spm_ff & f_word.last
        : last_ff));
    end
  end

  // ****************************************************************
  // Service request.
  // ****************************************************************
  logic srq_oen_ff;
  logic nxt_rsv;

  assign nxt_rsv = srq_event | (rsv_ff & ~stb_sent);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rsv_ff <= 1'b0;
      srq_oen_ff <= 1'b1;
    end else begin
      rsv_ff <= nxt_rsv;
      srq_oen_ff <= ~nxt_rsv;
    end
  end

  // ****************************************************************
  // Outputs. ATN, IFC and REN have no drivers here.
  // ****************************************************************
  assign bus_o = '{dio_n: dio_n_ff, dio_oen: dio_oen_ff,
    eoi_n: eoi_oen_ff, eoi_oen: eoi_oen_ff,
    dav_n: dav_oen_ff, dav_oen: dav_oen_ff,
    nrfd_n: nrfd_oen_ff, nrfd_oen: nrfd_oen_ff,
    ndac_n: ndac_oen_ff, ndac_oen: ndac_oen_ff,
    srq_n: srq_oen_ff, srq_oen: srq_oen_ff};
  assign rx_valid = rx_valid_ff;
  assign rx_data = rx_ff;
  assign dev_clear = dev_clear_ff;
  assign talker = talk_ff;
  assign listener = listen_ff;
  assign spoll = spm_ff;
  assign rsv = rsv_ff;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  a_dav_talker_only:
    assert property (@(posedge mclk) disable iff (!rstn)
      !dav_oen_ff |-> $past(talk_ff | talk_only) && !$past(atn))
    else $error("DAV driven while not active talker.");

  a_dav_after_rfd:
    assert property (@(posedge mclk) disable iff (!rstn)
      $fell(dav_oen_ff) |-> $past(bus_i.nrfd_n))
    else $error("DAV asserted before NRFD release.");

  a_acc_lines_gate:
    assert property (@(posedge mclk) disable iff (!rstn)
      (!nrfd_oen_ff || !ndac_oen_ff) |-> $past(listen_ff | atn))
    else $error("Acceptor lines driven while inactive.");

  a_mla_drop_talk:
    assert property (@(posedge mclk) disable iff (!rstn)
      cmd_cap && is_mla && !ifc |=> listen_ff && !talk_ff)
    else $error("Own listen address left talker state.");

  a_mta_drop_listen:
    assert property (@(posedge mclk) disable iff (!rstn)
      cmd_cap && is_mta && !ifc |=> talk_ff && !listen_ff)
    else $error("Own talk address left listener state.");

  a_unl_unlisten:
    assert property (@(posedge mclk) disable iff (!rstn)
      cmd_cap && cmd == `GTL_CMD_UNL |=> !listen_ff)
    else $error("Unlisten did not clear listener.");

  a_ifc_release:
    assert property (@(posedge mclk) disable iff (!rstn)
      ifc |=> !talk_ff && !listen_ff && !spm_ff && dav_oen_ff
        && nrfd_oen_ff && ndac_oen_ff && dio_oen_ff)
    else $error("Interface clear left state or lines.");

  a_sdc_needs_lad:
    assert property (@(posedge mclk) disable iff (!rstn)
      cmd_cap && cmd == `GTL_CMD_SDC && !listen_ff |=> !dev_clear_ff)
    else $error("Selective clear acted while unaddressed.");

  a_dcl_clears:
    assert property (@(posedge mclk) disable iff (!rstn)
      cmd_cap && cmd == `GTL_CMD_DCL |=> dev_clear_ff ##1 !dev_clear_ff)
    else $error("Device clear pulse wrong.");

  a_eoi_option:
    assert property (@(posedge mclk) disable iff (!rstn)
      !eoi_oen_ff |-> $past(eoi_out_en) && !dio_oen_ff)
    else $error("EOI driven without option.");

  a_rx_end_option:
    assert property (@(posedge mclk) disable iff (!rstn)
      rx_valid_ff && rx_ff.last |-> $past(eoi_in_en && eoi))
    else $error("End mark without EOI option.");

  a_srq_on_event:
    assert property (@(posedge mclk) disable iff (!rstn)
      srq_event |=> rsv_ff && !srq_oen_ff)
    else $error("Service request not raised.");

  a_stb_clears_rsv:
    assert property (@(posedge mclk) disable iff (!rstn)
      stb_sent && !srq_event |=> !rsv_ff && srq_oen_ff)
    else $error("Request not cleared after poll.");
endmodule
`default_nettype wire

// *** tb/gtl_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Controller-in-charge with one listener on the far side.
// ************************************************************
module gtl_bus_model
  import gtl_pkg::*;
(
  input wire logic mclk,
  input wire gtl_bus_out_t bus_o,
  output gtl_bus_in_t bus_i
);
  logic atn_n = 1'b1;
  logic ifc_n = 1'b1;
  logic ren_n = 1'b0;
  logic eoi_n = 1'b1;
  logic dav_n = 1'b1;
  logic nrfd_n = 1'b0;
  logic ndac_n = 1'b0;
  logic [7:0] dio_n = 8'hFF;
  logic ok = 1'b1;

  // Open-drain lines with pull-ups, so a released line reads high.
  always_comb begin
    bus_i.atn_n = atn_n;
    bus_i.ifc_n = ifc_n;
    bus_i.ren_n = ren_n;
    bus_i.eoi_n = eoi_n & (bus_o.eoi_oen | bus_o.eoi_n);
    bus_i.dav_n = dav_n & (bus_o.dav_oen | bus_o.dav_n);
    bus_i.nrfd_n = nrfd_n & (bus_o.nrfd_oen | bus_o.nrfd_n);
    bus_i.ndac_n = ndac_n & (bus_o.ndac_oen | bus_o.ndac_n);
    bus_i.dio_n = dio_n & (bus_o.dio_n | {8{bus_o.dio_oen}});
  end

  function automatic logic lvl(input int s);
    return s == 0 ? bus_i.nrfd_n : (s == 1 ? bus_i.ndac_n : bus_i.dav_n);
  endfunction

  task automatic wait_line(input int s, input logic v);
    int n;
    n = 0;
    while (lvl(s) !== v && n < 300) begin
      @(negedge mclk);
      n++;
    end
    if (n == 300)
      ok = 1'b0;
  endtask

  // Talker side: commands go under attention, data without.
  task automatic send(input logic [7:0] b, input logic atn, input logic e);
    @(negedge mclk);
    atn_n = ~atn;
    nrfd_n = 1'b1;
    ndac_n = 1'b1;
    wait_line(1, 1'b0);
    wait_line(0, 1'b1);
    dio_n = ~b;
    eoi_n = ~e;
    @(negedge mclk);
    dav_n = 1'b0;
    wait_line(1, 1'b1);
    dav_n = 1'b1;
    @(negedge mclk);
    dio_n = 8'hFF;
    eoi_n = 1'b1;
    nrfd_n = 1'b0;
    ndac_n = 1'b0;
  endtask

  task automatic atn_off();
    @(negedge mclk);
    atn_n = 1'b1;
  endtask

  // Listener side: gap stretches each acceptance to stall the talker.
  task automatic take(input int gap, output logic [8:0] w);
    @(negedge mclk);
    nrfd_n = 1'b1;
    wait_line(2, 1'b0);
    w = {~bus_i.eoi_n, ~bus_i.dio_n};
    nrfd_n = 1'b0;
    repeat (gap) @(negedge mclk);
    ndac_n = 1'b1;
    wait_line(2, 1'b1);
    ndac_n = 1'b0;
  endtask

  task automatic pulse_ifc();
    @(negedge mclk);
    ifc_n = 1'b0;
    repeat (3) @(negedge mclk);
    ifc_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** tb/test_gtl_talker_listener.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gtl_cfg.svh"
// ************************************************************
// Self-checking bench.
// ************************************************************
module test_gtl_talker_listener
  import gtl_pkg::*;
();
  localparam logic [4:0] ADDR = 5'h1E;
  localparam logic [7:0] MLA = {3'h1, ADDR};
  localparam logic [7:0] MTA = {3'h2, ADDR};
  localparam logic [7:0] OTA = {3'h2, 5'h1D};
  localparam logic [8:0] TQ [3] = '{9'h0A1, 9'h0B2, 9'h1C3};
  logic mclk, rstn, talk_only, eoi_out_en, eoi_in_en, srq_event;
  logic [4:0] bus_addr;
  logic [7:0] status_byte;
  logic tx_valid, tx_ready, rx_valid, dev_clear, talker, listener;
  logic spoll, rsv;
  logic [8:0] w;
  gtl_word_t tx_data, rx_data;
  gtl_bus_in_t bus_i;
  gtl_bus_out_t bus_o;
  int miscompares = 0;
  int tests_run = 0;
  int rx_cnt = 0;
  int clr_cnt = 0;

  gtl_talker_listener u_dut (
    .mclk, .rstn, .bus_i, .bus_o, .bus_addr, .talk_only, .eoi_out_en,
    .eoi_in_en, .srq_event, .status_byte, .tx_valid, .tx_ready, .tx_data,
    .rx_valid, .rx_data, .dev_clear, .talker, .listener, .spoll, .rsv
  );
  gtl_bus_model u_bm (.mclk, .bus_o, .bus_i);

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (rx_valid === 1'b1)
      rx_cnt++;
    if (dev_clear === 1'b1)
      clr_cnt++;
  end

  function automatic logic [5:0] oens();
    return {bus_o.dio_oen, bus_o.eoi_oen, bus_o.dav_oen,
            bus_o.nrfd_oen, bus_o.ndac_oen, bus_o.srq_oen};
  endfunction

  task automatic check(input string what, input logic [8:0] exp,
                       input logic [8:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic push(input logic [8:0] d);
    int n;
    n = 0;
    @(negedge mclk);
    tx_valid = 1'b1;
    tx_data = d;
    while (tx_ready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    tx_valid = 1'b0;
  endtask

  task automatic done(input string n);
    check("handshake", 9'h001, 9'(u_bm.ok));
    $display("test %s finished", n);
  endtask

  task automatic t_reset();
    check("released", 9'h03F, 9'(oens()));
    check("flags", 9'h000, 9'({talker, listener, spoll, rsv}));
    check("tx_ready", 9'h001, 9'(tx_ready));
    done("reset");
  endtask

  task automatic t_listen();
    eoi_in_en = 1'b1;
    u_bm.send({1'b1, MLA[6:0]}, 1'b1, 1'b0);
    check("listener", 9'h001, 9'(listener));
    check("rx count", 9'h000, 9'(rx_cnt));
    u_bm.send(8'h5A, 1'b0, 1'b0);
    check("rx", 9'h05A, rx_data);
    u_bm.send(8'hC3, 1'b0, 1'b1);
    check("rx", 9'h1C3, rx_data);
    eoi_in_en = 1'b0;
    u_bm.send(8'h11, 1'b0, 1'b1);
    check("rx", 9'h011, rx_data);
    check("rx count", 9'h003, 9'(rx_cnt));
    tick(2);
    check("ndac_oen", 9'h000, 9'(bus_o.ndac_oen));
    done("listen");
  endtask

  task automatic t_clear();
    u_bm.send({1'b0, `GTL_CMD_SDC}, 1'b1, 1'b0);
    check("clear", 9'h001, 9'(clr_cnt));
    u_bm.send({1'b1, `GTL_CMD_DCL}, 1'b1, 1'b0);
    check("clear", 9'h002, 9'(clr_cnt));
    u_bm.send({1'b0, `GTL_CMD_UNL}, 1'b1, 1'b0);
    check("listener", 9'h000, 9'(listener));
    u_bm.send({1'b0, `GTL_CMD_SDC}, 1'b1, 1'b0);
    tick(2);
    check("clear", 9'h002, 9'(clr_cnt));
    u_bm.atn_off();
    tick(3);
    check("acc oen", 9'h003, 9'({bus_o.nrfd_oen, bus_o.ndac_oen}));
    done("clear");
  endtask

  task automatic t_talk();
    u_bm.send(MLA, 1'b1, 1'b0);
    u_bm.send(MTA, 1'b1, 1'b0);
    check("listener", 9'h000, 9'(listener));
    check("talker", 9'h001, 9'(talker));
    eoi_out_en = 1'b1;
    for (int i = 0; i < 3; i++)
      push(TQ[i]);
    u_bm.atn_off();
    for (int i = 0; i < 3; i++) begin
      u_bm.take(3, w);
      check("byte", TQ[i], w);
    end
    u_bm.send(MLA, 1'b1, 1'b0);
    check("talker", 9'h000, 9'(talker));
    u_bm.send(MTA, 1'b1, 1'b0);
    u_bm.send(OTA, 1'b1, 1'b0);
    check("talker", 9'h000, 9'(talker));
    u_bm.send({1'b0, `GTL_CMD_UNL}, 1'b1, 1'b0);
    check("dav_oen", 9'h001, 9'(bus_o.dav_oen));
    done("talk");
  endtask

  task automatic t_poll();
    eoi_out_en = 1'b0;
    status_byte = 8'h05;
    srq_event = 1'b1;
    tick(1);
    srq_event = 1'b0;
    tick(2);
    check("srq", 9'h002, 9'({rsv, bus_o.srq_oen}));
    u_bm.send({1'b0, `GTL_CMD_SPE}, 1'b1, 1'b0);
    u_bm.send(MTA, 1'b1, 1'b0);
    check("spoll", 9'h001, 9'(spoll));
    u_bm.atn_off();
    u_bm.take(0, w);
    check("status", 9'h045, w);
    tick(3);
    check("srq", 9'h001, 9'({rsv, bus_o.srq_oen}));
    u_bm.send({1'b0, `GTL_CMD_SPD}, 1'b1, 1'b0);
    check("spoll", 9'h000, 9'(spoll));
    u_bm.send(OTA, 1'b1, 1'b0);
    u_bm.atn_off();
    done("poll");
  endtask

  task automatic t_fill();
    talk_only = 1'b1;
    for (int i = 0; i < `GTL_FIFO_DEPTH; i++)
      push({i == 15, 8'h30 + 8'(i)});
    tick(1);
    check("tx_ready", 9'h000, 9'(tx_ready));
    for (int i = 0; i < `GTL_FIFO_DEPTH; i++) begin
      u_bm.take(i % 3, w);
      check("byte", {1'b0, 8'h30 + 8'(i)}, w);
    end
    check("tx_ready", 9'h001, 9'(tx_ready));
    talk_only = 1'b0;
    done("fill");
  endtask

  task automatic t_ifc();
    u_bm.send(MTA, 1'b1, 1'b0);
    push(9'h077);
    u_bm.atn_off();
    tick(4);
    check("dio", 9'h088, 9'({bus_o.dio_oen, bus_o.dio_n}));
    u_bm.pulse_ifc();
    tick(1);
    check("talker", 9'h000, 9'(talker));
    check("released", 9'h03F, 9'(oens()));
    u_bm.send(MTA, 1'b1, 1'b0);
    u_bm.atn_off();
    u_bm.take(1, w);
    check("resent", 9'h077, w);
    done("ifc");
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    bus_addr = ADDR;
    talk_only = 1'b0;
    eoi_out_en = 1'b0;
    eoi_in_en = 1'b0;
    srq_event = 1'b0;
    status_byte = 8'h00;
    tx_valid = 1'b0;
    tx_data = 9'h000;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    tick(1);
    t_reset();
    t_listen();
    t_clear();
    t_talk();
    t_poll();
    t_fill();
    t_ifc();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
